// ---- hw/tcc_pkg.sv ----
// Package for the timer capture and compare channel block: map, fields and codes
package tcc_pkg;

	// ==========================================================
	// Register byte offsets on APB
	localparam logic [7:0] CAP_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] CAP_BUF_OFFSET = 8'h04;
	localparam logic [7:0] CMP_CTRL_OFFSET = 8'h08;
	localparam logic [7:0] CMP_PRIMARY_OFFSET = 8'h0C;
	localparam logic [7:0] CMP_SECONDARY_OFFSET = 8'h10;

	// ==========================================================
	// Field positions in both control registers
	localparam int STOP_IDLE_BIT = 13;
	localparam int CAP_TIMER_SEL_BIT = 7;
	localparam int CAP_PER_IRQ_LSB = 5;
	localparam int CAP_OVERFLOW_BIT = 4;
	localparam int CAP_NOT_EMPTY_BIT = 3;
	localparam int CMP_FAULT_BIT = 4;
	localparam int CMP_TIMER_SEL_BIT = 3;
	localparam int MODE_LSB = 0;

	// ==========================================================
	// Sizes and reset values
	localparam int FIFO_DEPTH = 4;
	localparam logic [2:0] FIFO_COUNT_FULL = 3'h4;
	localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [31:0] READ_ZERO = 32'h00000000;

	// ==========================================================
	// Mode codes
	typedef enum logic [2:0] {
		CAP_OFF = 3'b000,
		CAP_EVERY_EDGE = 3'b001,
		CAP_FALLING = 3'b010,
		CAP_RISING = 3'b011,
		CAP_RISE_4TH = 3'b100,
		CAP_RISE_16TH = 3'b101,
		CAP_UNUSED = 3'b110,
		CAP_WAKE_ONLY = 3'b111
	} tcc_cap_mode_e;

	typedef enum logic [2:0] {
		CMP_OFF = 3'b000,
		CMP_SET_HIGH = 3'b001,
		CMP_SET_LOW = 3'b010,
		CMP_TOGGLE = 3'b011,
		CMP_SINGLE_PULSE = 3'b100,
		CMP_PULSE_TRAIN = 3'b101,
		CMP_PWM = 3'b110,
		CMP_PWM_FAULT = 3'b111
	} tcc_cmp_mode_e;

	// ==========================================================
	// Writable control fields
	typedef struct packed {
		logic stop_in_idle;
		logic timer_select;
		logic [1:0] captures_per_interrupt;
		tcc_cap_mode_e mode;
	} tcc_cap_ctrl_s;

	typedef struct packed {
		logic stop_in_idle;
		logic timer_select;
		tcc_cmp_mode_e mode;
	} tcc_cmp_ctrl_s;

	localparam tcc_cap_ctrl_s CAP_CTRL_RESET = '{1'b0, 1'b0, 2'b00, CAP_OFF};
	localparam tcc_cmp_ctrl_s CMP_CTRL_RESET = '{1'b0, 1'b0, CMP_OFF};

endpackage

// ---- hw/tcc_channels.sv ----
// One capture channel and one compare channel on two shared timers, APB slave
//
// Contract
// - Qualifying capture event stores selected 16-bit timer count.
// - Capture modes 011 rising, 010 falling, 001 both edges.
// - Mode 101 captures every 16th rising edge, 100 every 4th.
// - Capture modes 000 and 110 leave the channel disabled.
// - Mode 111: rising edge only wakes/interrupts during sleep or idle.
// - Interrupt after 1..4 captures; every-edge mode interrupts each capture.
// - Capture timer select set takes first timer, clear takes second.
// - Four-entry first-in first-out buffer of capture values.
// - Read-only overflow flag, set by hardware, cleared by hardware.
// - Read-only not-empty flag shows unread values remain.
// - Stop-in-idle bit halts channel while CPU is idle; compare_output_pin is not halted and still loads next_pin or the fault low.
// - Compare timer select set takes second timer, clear takes first.
// - Mode 001 starts low, goes high on match, interrupts then.
// - Mode 010 starts high, goes low on match, interrupts then.
// - Mode 011 keeps level, toggles each match, interrupts each edge.
// - Mode 100 starts low, one pulse from both values, interrupt on fall.
// - Mode 101 starts low, repeating pulses, interrupt each fall.
// - Mode 110 PWM, starts high unless primary zero, no interrupt.
// - Mode 111 PWM with fault input, interrupt on fault falling edge.
// - Read-only fault status set by hardware fault, cleared by hardware.
// - Compare mode 000 hands the pin to the port register.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module tcc_channels (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] first_timer_count,
	input wire logic [15:0] second_timer_count,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	input wire logic capture_input_pin,
	input wire logic first_fault_input,
	input wire logic port_output_value,
	output logic compare_output_pin,
	output logic capture_interrupt,
	output logic capture_wake,
	output logic compare_interrupt
);

	// ==========================================================
	// APB decode
	tcc_pkg::tcc_cap_ctrl_s cap_ctrl;
	tcc_pkg::tcc_cmp_ctrl_s cmp_ctrl;
	logic [15:0] primary_compare_value;
	logic [15:0] secondary_compare_value;
	logic read_pop_ok;
	wire logic [7:0] reg_addr = paddr[7:0];
	wire logic addr_high_zero = (paddr[31:8] == 24'h000000);
	wire logic hit_cap_ctrl = addr_high_zero && (reg_addr == tcc_pkg::CAP_CTRL_OFFSET);
	wire logic hit_cap_buf = addr_high_zero && (reg_addr == tcc_pkg::CAP_BUF_OFFSET);
	wire logic hit_cmp_ctrl = addr_high_zero && (reg_addr == tcc_pkg::CMP_CTRL_OFFSET);
	wire logic hit_primary = addr_high_zero && (reg_addr == tcc_pkg::CMP_PRIMARY_OFFSET);
	wire logic hit_secondary = addr_high_zero && (reg_addr == tcc_pkg::CMP_SECONDARY_OFFSET);
	wire logic hit_any = hit_cap_ctrl | hit_cap_buf | hit_cmp_ctrl | hit_primary | hit_secondary;
	wire logic setup_phase = psel && !penable;
	wire logic access_phase = psel && penable;
	wire logic wr_cap_ctrl = access_phase && pwrite && hit_cap_ctrl;
	wire logic wr_cmp_ctrl = access_phase && pwrite && hit_cmp_ctrl;
	wire logic wr_primary = access_phase && pwrite && hit_primary;
	wire logic wr_secondary = access_phase && pwrite && hit_secondary;

	// Read data is latched in setup so the answer comes from a flip-flop
	assign pready = access_phase;
	assign pslverr = access_phase && !hit_any;

	// ==========================================================
	// Capture channel
	logic [15:0] fifo_mem [tcc_pkg::FIFO_DEPTH];
	logic [1:0] fifo_wr_ptr;
	logic [1:0] fifo_rd_ptr;
	logic [2:0] fifo_count;
	logic capture_overflow_flag;
	logic capture_pin_prev;
	logic [3:0] prescale_count;
	logic [1:0] irq_count;

	wire logic cap_halted = cap_ctrl.stop_in_idle && cpu_idle;
	wire logic pin_rise = capture_input_pin && !capture_pin_prev;
	wire logic pin_fall = !capture_input_pin && capture_pin_prev;
	wire logic capture_buffer_not_empty = (fifo_count != 3'h0);
	wire logic fifo_full = (fifo_count == tcc_pkg::FIFO_COUNT_FULL);
	wire logic [15:0] cap_timer = cap_ctrl.timer_select ? first_timer_count : second_timer_count;
	wire logic prescale_last_4 = (prescale_count[1:0] == tcc_pkg::PRESCALE_4_LAST[1:0]);
	wire logic prescale_last_16 = (prescale_count == tcc_pkg::PRESCALE_16_LAST);
	logic cap_event;
	always_comb begin
		case (cap_ctrl.mode)
			tcc_pkg::CAP_EVERY_EDGE: cap_event = pin_rise | pin_fall;
			tcc_pkg::CAP_FALLING: cap_event = pin_fall;
			tcc_pkg::CAP_RISING: cap_event = pin_rise;
			tcc_pkg::CAP_RISE_4TH: cap_event = pin_rise && prescale_last_4;
			tcc_pkg::CAP_RISE_16TH: cap_event = pin_rise && prescale_last_16;
			// off, unused and wake-only modes take no capture
			default: cap_event = 1'b0;
		endcase
	end
	wire logic cap_take = cap_event && !cap_halted;
	wire logic cap_push = cap_take && !fifo_full;
	// pop on the completing read of the buffer word
	wire logic cap_pop = access_phase && !pwrite && hit_cap_buf && read_pop_ok;
	wire logic irq_count_done = (irq_count == cap_ctrl.captures_per_interrupt);
	// every-edge mode ignores the count field
	wire logic next_cap_irq = cap_take && ((cap_ctrl.mode == tcc_pkg::CAP_EVERY_EDGE) || irq_count_done);
	// wake and interrupt only in sleep or idle
	wire logic next_wake = (cap_ctrl.mode == tcc_pkg::CAP_WAKE_ONLY) && pin_rise && (cpu_sleep || cpu_idle);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			capture_pin_prev <= 1'b0;
			prescale_count <= 4'h0;
			irq_count <= 2'b00;
			capture_interrupt <= 1'b0;
			capture_wake <= 1'b0;
		end else begin
			capture_pin_prev <= capture_input_pin;
			capture_interrupt <= next_cap_irq || next_wake;
			capture_wake <= next_wake;
			if (cap_ctrl.mode == tcc_pkg::CAP_OFF) begin
				prescale_count <= 4'h0;
				irq_count <= 2'b00;
			end else if (!cap_halted) begin
				if (pin_rise)
					prescale_count <= 4'(prescale_count + 4'h1);
				if (cap_take)
					irq_count <= irq_count_done ? 2'b00 : 2'(irq_count + 2'b01);
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fifo_wr_ptr <= 2'b00;
			fifo_rd_ptr <= 2'b00;
			fifo_count <= 3'h0;
		end else begin
			if (cap_push)
				fifo_wr_ptr <= 2'(fifo_wr_ptr + 2'b01);
			if (cap_pop)
				fifo_rd_ptr <= 2'(fifo_rd_ptr + 2'b01);
			if (cap_push && !cap_pop)
				fifo_count <= 3'(fifo_count + 3'h1);
			else if (cap_pop && !cap_push)
				fifo_count <= 3'(fifo_count - 3'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (cap_push)
			fifo_mem[fifo_wr_ptr] <= cap_timer;
	end

	// overflow set by hardware; cleared when the channel is turned off or buffer drained
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			capture_overflow_flag <= 1'b0;
		else if (cap_take && fifo_full)
			capture_overflow_flag <= 1'b1;
		else if (cap_ctrl.mode == tcc_pkg::CAP_OFF || (cap_pop && fifo_count == 3'h1))
			capture_overflow_flag <= 1'b0;
	end

	// ==========================================================
	// Compare channel
	logic pin_level;
	logic pulse_done;
	logic fault_prev;
	logic compare_fault_status;
	logic [2:0] cmp_mode_prev;
	logic [15:0] pwm_duty;
	logic [15:0] cmp_timer_prev;

	localparam logic [15:0] VALUE_ZERO = tcc_pkg::VALUE_RESET;
	wire logic cmp_halted = cmp_ctrl.stop_in_idle && cpu_idle;
	wire logic [15:0] cmp_timer = cmp_ctrl.timer_select ? second_timer_count : first_timer_count;
	wire logic cmp_entry = (cmp_ctrl.mode != cmp_mode_prev);
	wire logic cmp_timer_moved = (cmp_timer != cmp_timer_prev);
	wire logic match_primary = cmp_timer_moved && (cmp_timer == primary_compare_value);
	wire logic match_secondary = cmp_timer_moved && (cmp_timer == secondary_compare_value);
	wire logic period_start = cmp_timer_moved && (cmp_timer == VALUE_ZERO);
	wire logic fault_fall = fault_prev && !first_fault_input;
	wire logic pwm_start_level = (primary_compare_value != VALUE_ZERO);

	logic next_pin;
	logic next_done;
	logic next_cmp_irq;
	always_comb begin
		next_pin = pin_level;
		next_done = pulse_done;
		next_cmp_irq = 1'b0;
		case (cmp_ctrl.mode)
			tcc_pkg::CMP_SET_HIGH: begin
				if (cmp_entry)
					next_pin = 1'b0;
				else if (match_primary && !pin_level) begin
					next_pin = 1'b1;
					next_cmp_irq = 1'b1;
				end
			end
			tcc_pkg::CMP_SET_LOW: begin
				if (cmp_entry)
					next_pin = 1'b1;
				else if (match_primary && pin_level) begin
					next_pin = 1'b0;
					next_cmp_irq = 1'b1;
				end
			end
			tcc_pkg::CMP_TOGGLE: begin
				if (!cmp_entry && match_primary) begin
					next_pin = !pin_level;
					next_cmp_irq = 1'b1;
				end
			end
			// pulse rises at primary, falls at secondary
			tcc_pkg::CMP_SINGLE_PULSE, tcc_pkg::CMP_PULSE_TRAIN: begin
				if (cmp_entry) begin
					next_pin = 1'b0;
					next_done = 1'b0;
				end else if (!pulse_done) begin
					if (pin_level && match_secondary) begin
						next_pin = 1'b0;
						next_cmp_irq = 1'b1;
						next_done = (cmp_ctrl.mode == tcc_pkg::CMP_SINGLE_PULSE);
					end else if (!pin_level && match_primary)
						next_pin = 1'b1;
				end
			end
			// PWM; duty reloads at the period start
			tcc_pkg::CMP_PWM, tcc_pkg::CMP_PWM_FAULT: begin
				if (cmp_entry)
					next_pin = pwm_start_level;
				else if (period_start)
					next_pin = (secondary_compare_value != VALUE_ZERO);
				else if (cmp_timer_moved && cmp_timer == pwm_duty)
					next_pin = 1'b0;
				if (cmp_ctrl.mode == tcc_pkg::CMP_PWM_FAULT && fault_fall)
					next_cmp_irq = 1'b1;
			end
			default: begin
				next_pin = pin_level;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_level <= 1'b0;
			pulse_done <= 1'b0;
			cmp_mode_prev <= tcc_pkg::CMP_OFF;
			cmp_timer_prev <= VALUE_ZERO;
			pwm_duty <= VALUE_ZERO;
			fault_prev <= 1'b1;
			compare_interrupt <= 1'b0;
		end else begin
			fault_prev <= first_fault_input;
			if (!cmp_halted) begin
				pin_level <= next_pin;
				pulse_done <= next_done;
				cmp_mode_prev <= cmp_ctrl.mode;
				cmp_timer_prev <= cmp_timer;
				compare_interrupt <= next_cmp_irq;
				if (cmp_entry)
					pwm_duty <= primary_compare_value;
				else if (period_start)
					pwm_duty <= secondary_compare_value;
			end else
				compare_interrupt <= 1'b0;
		end
	end

	// fault latch, cleared by hardware when the mode changes or a new period starts
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			compare_fault_status <= 1'b0;
		else if (cmp_ctrl.mode == tcc_pkg::CMP_PWM_FAULT && !first_fault_input)
			compare_fault_status <= 1'b1;
		else if (cmp_ctrl.mode != tcc_pkg::CMP_PWM_FAULT || period_start)
			compare_fault_status <= 1'b0;
	end

	// port register owns the pin when off; a fault forces the pin low
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			compare_output_pin <= 1'b0;
		else if (cmp_ctrl.mode == tcc_pkg::CMP_OFF)
			compare_output_pin <= port_output_value;
		else if (compare_fault_status || (cmp_ctrl.mode == tcc_pkg::CMP_PWM_FAULT && !first_fault_input))
			compare_output_pin <= 1'b0;
		else
			compare_output_pin <= next_pin;
	end

	// ==========================================================
	// Register writes
	// control writes take effect at once; software must stop the timer first
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cap_ctrl <= tcc_pkg::CAP_CTRL_RESET;
			cmp_ctrl <= tcc_pkg::CMP_CTRL_RESET;
			primary_compare_value <= VALUE_ZERO;
			secondary_compare_value <= VALUE_ZERO;
		end else begin
			if (wr_cap_ctrl) begin
				cap_ctrl.stop_in_idle <= pwdata[tcc_pkg::STOP_IDLE_BIT];
				cap_ctrl.timer_select <= pwdata[tcc_pkg::CAP_TIMER_SEL_BIT];
				cap_ctrl.captures_per_interrupt <= pwdata[tcc_pkg::CAP_PER_IRQ_LSB +: 2];
				cap_ctrl.mode <= tcc_pkg::tcc_cap_mode_e'(pwdata[tcc_pkg::MODE_LSB +: 3]);
			end
			if (wr_cmp_ctrl) begin
				cmp_ctrl.stop_in_idle <= pwdata[tcc_pkg::STOP_IDLE_BIT];
				cmp_ctrl.timer_select <= pwdata[tcc_pkg::CMP_TIMER_SEL_BIT];
				cmp_ctrl.mode <= tcc_pkg::tcc_cmp_mode_e'(pwdata[tcc_pkg::MODE_LSB +: 3]);
			end
			if (wr_primary)
				primary_compare_value <= pwdata[15:0];
			if (wr_secondary)
				secondary_compare_value <= pwdata[15:0];
		end
	end

	// ==========================================================
	// Register reads
	logic [31:0] read_word;
	always_comb begin
		read_word = tcc_pkg::READ_ZERO;
		if (hit_cap_ctrl) begin
			read_word[tcc_pkg::STOP_IDLE_BIT] = cap_ctrl.stop_in_idle;
			read_word[tcc_pkg::CAP_TIMER_SEL_BIT] = cap_ctrl.timer_select;
			read_word[tcc_pkg::CAP_PER_IRQ_LSB +: 2] = cap_ctrl.captures_per_interrupt;
			read_word[tcc_pkg::CAP_OVERFLOW_BIT] = capture_overflow_flag;
			read_word[tcc_pkg::CAP_NOT_EMPTY_BIT] = capture_buffer_not_empty;
			read_word[tcc_pkg::MODE_LSB +: 3] = cap_ctrl.mode;
		end else if (hit_cap_buf) begin
			// Empty buffer reads as zero and frees nothing
			if (capture_buffer_not_empty)
				read_word[15:0] = fifo_mem[fifo_rd_ptr];
		end else if (hit_cmp_ctrl) begin
			read_word[tcc_pkg::STOP_IDLE_BIT] = cmp_ctrl.stop_in_idle;
			read_word[tcc_pkg::CMP_FAULT_BIT] = compare_fault_status;
			read_word[tcc_pkg::CMP_TIMER_SEL_BIT] = cmp_ctrl.timer_select;
			read_word[tcc_pkg::MODE_LSB +: 3] = cmp_ctrl.mode;
		end else if (hit_primary)
			read_word[15:0] = primary_compare_value;
		else if (hit_secondary)
			read_word[15:0] = secondary_compare_value;
	end

	// Pop only what was actually shown, so a capture landing mid-read is not lost
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= tcc_pkg::READ_ZERO;
			read_pop_ok <= 1'b0;
		end else if (setup_phase) begin
			prdata <= read_word;
			read_pop_ok <= capture_buffer_not_empty;
		end
	end

endmodule

// ---- tb/tcc_channels_chk.sv ----
// Port checker of the capture and compare channels
`timescale 1ns/10ps
module tcc_channels_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	input wire logic capture_input_pin,
	input wire logic port_output_value,
	input wire logic compare_output_pin,
	input wire logic capture_interrupt,
	input wire logic capture_wake,
	input wire logic compare_interrupt
);
	// ====
	// Helper state: compare mode seen on the bus, cycles since the pin moved
	logic [2:0] mode;
	logic [2:0] since;
	logic pin_q;
	wire access = psel && penable;
	wire mapped = (paddr[31:8] == 24'h000000) && (paddr[7:0] inside {tcc_pkg::CAP_CTRL_OFFSET,
		tcc_pkg::CAP_BUF_OFFSET, tcc_pkg::CMP_CTRL_OFFSET, tcc_pkg::CMP_PRIMARY_OFFSET, tcc_pkg::CMP_SECONDARY_OFFSET});
	wire mode_wr = access && pwrite && mapped && paddr[7:0] == tcc_pkg::CMP_CTRL_OFFSET;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode <= 3'h0;
			since <= 3'h7;
			pin_q <= 1'b0;
		end else begin
			pin_q <= capture_input_pin;
			if (mode_wr)
				mode <= pwdata[2:0];
			// Saturates so an old edge never excuses a late interrupt
			if (capture_input_pin != pin_q)
				since <= 3'h0;
			else if (since != 3'h7)
				since <= since + 3'h1;
		end
	end
	// ====
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_ready_zero_wait: assert property (access |-> pready) else $error("pready low in access phase");
	a_unmapped_err: assert property (access |-> pslverr == !mapped) else $error("pslverr wrong for address");
	a_cap_irq_cause: assert property (capture_interrupt |-> since <= 3'h3)
		else $error("capture interrupt without a recent pin edge");
	a_wake_pair: assert property (capture_wake |-> capture_interrupt)
		else $error("wake pulse without interrupt");
	a_wake_power: assert property (capture_wake |-> $past(cpu_idle) || $past(cpu_sleep))
		else $error("wake pulse while running");
	a_port_follow: assert property (mode == 3'h0 && $past(mode) == 3'h0 |-> compare_output_pin == $past(port_output_value))
		else $error("disabled compare pin not following port");
	a_rise_on_set: assert property (mode == 3'h1 && compare_interrupt |-> compare_output_pin && !$past(compare_output_pin))
		else $error("set-high interrupt without rising pin");
	a_fall_on_clear: assert property (mode == 3'h2 && compare_interrupt |-> !compare_output_pin && $past(compare_output_pin))
		else $error("set-low interrupt without falling pin");
	a_toggle_edge: assert property (mode == 3'h3 && compare_interrupt |-> compare_output_pin != $past(compare_output_pin))
		else $error("toggle interrupt without pin change");
	a_pulse_fall: assert property (mode inside {3'h4, 3'h5} && compare_interrupt |-> $fell(compare_output_pin))
		else $error("pulse interrupt off the falling edge");
	a_pwm_quiet: assert property (mode == 3'h6 && $past(mode) == 3'h6 |-> !compare_interrupt)
		else $error("interrupt in plain pwm mode");
	cover property (capture_wake);
	cover property (mode == 3'h3 && compare_interrupt);
	cover property (access && pslverr);
endmodule
bind tcc_channels tcc_channels_chk u_tcc_channels_chk (.*);

// ---- tb/tcc_far_side.sv ----
// Far-side model: capture pulse source and fault line
`timescale 1ns/10ps
module tcc_far_side (
	input wire logic clk,
	output logic capture_input_pin,
	output logic first_fault_input
);
	// ====
	// Fault line idles high because a fault is signalled low
	initial begin
		capture_input_pin = 1'b0;
		first_fault_input = 1'b1;
	end
	task automatic pulse(input int width);
		@(posedge clk);
		capture_input_pin <= 1'b1;
		repeat (width) @(posedge clk);
		capture_input_pin <= 1'b0;
		repeat (width) @(posedge clk);
	endtask
	task automatic fault(input int width);
		@(posedge clk);
		first_fault_input <= 1'b0;
		repeat (width) @(posedge clk);
		first_fault_input <= 1'b1;
	endtask
endmodule

// ---- tb/tcc_channels_tb.sv ----
// Self-checking bench of the capture and compare channels
`timescale 1ns/10ps
module tcc_channels_tb;
	logic clk, reset, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic [15:0] first_timer_count, second_timer_count;
	logic cpu_idle, cpu_sleep, capture_input_pin, first_fault_input, port_output_value;
	logic compare_output_pin, capture_interrupt, capture_wake, compare_interrupt;
	int err_count = 0;
	int check_count = 0;
	int cap_irqs, wakes, cmp_irqs;
	tcc_channels u_tcc_channels (.*);
	tcc_far_side u_tcc_far_side (.clk, .capture_input_pin, .first_fault_input);
	// ====
	// Clock and event counters
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (capture_interrupt === 1'b1) cap_irqs++;
		if (capture_wake === 1'b1) wakes++;
		if (compare_interrupt === 1'b1) cmp_irqs++;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask
	// ====
	// Bus access
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic e);
		int n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {24'h000000, a};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) chk("pready", 32'h1, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r);
	endtask
	// ====
	// Capture run: expected buffer worked out per pin edge
	task automatic cap_run(input logic [15:0] ctrl, input int n, input logic [1:0] pw);
		logic [15:0] q[$];
		logic ov = 1'b0;
		int ncap = 0;
		int k;
		logic [2:0] m;
		m = ctrl[2:0];
		wr(tcc_pkg::CAP_CTRL_OFFSET, 32'h0);
		{cpu_sleep, cpu_idle} <= pw;
		wr(tcc_pkg::CAP_CTRL_OFFSET, {16'h0000, ctrl});
		cap_irqs = 0;
		wakes = 0;
		for (int i = 1; i <= n; i++) begin
			first_timer_count <= 16'h1000 + 16'(i);
			second_timer_count <= 16'h8000 + 16'(i);
			u_tcc_far_side.pulse(3);
			k = int'(m == 3'b011 || m == 3'b001 || (m == 3'b100 && i % 4 == 0) || (m == 3'b101 && i % 16 == 0));
			k += int'(m == 3'b010 || m == 3'b001);
			if (pw[0] && ctrl[13]) k = 0;
			repeat (k) begin
				if (q.size() < 4) q.push_back(ctrl[7] ? 16'h1000 + 16'(i) : 16'h8000 + 16'(i));
				else ov = 1'b1;
				ncap++;
			end
		end
		repeat (4) @(posedge clk);
		if (m == 3'b111) chk("wake pulses", n, wakes);
		k = (m == 3'b111) ? n : (m == 3'b001) ? ncap : ncap / (ctrl[6:5] + 1);
		if (ncap <= 4) chk("capture irqs", k, cap_irqs);
		rdc("capture status", tcc_pkg::CAP_CTRL_OFFSET, {16'h0, (ctrl & 16'h20E7) | {11'h0, ov, q.size() != 0, 3'h0}});
		while (q.size() > 0) rdc("capture value", tcc_pkg::CAP_BUF_OFFSET, {16'h0, q.pop_front()});
		rdc("empty buffer", tcc_pkg::CAP_BUF_OFFSET, 32'h0);
		rdc("drained status", tcc_pkg::CAP_CTRL_OFFSET, {16'h0, ctrl & 16'h20E7});
		{cpu_sleep, cpu_idle} <= 2'h0;
	endtask
	task automatic sweep(input logic second);
		for (int t = 0; t < 8; t++) begin
			@(posedge clk);
			if (second) second_timer_count <= 16'(t);
			else first_timer_count <= 16'(t);
		end
	endtask
	// Timers are held still while control is written
	task automatic cmp_run(input logic [15:0] ctrl, input logic [15:0] pv, input logic [15:0] sv, input logic [1:0] lv, input int irqs);
		first_timer_count <= 16'hFFFF;
		second_timer_count <= 16'hFFFF;
		wr(tcc_pkg::CMP_CTRL_OFFSET, 32'h0);
		wr(tcc_pkg::CMP_PRIMARY_OFFSET, {16'h0, pv});
		wr(tcc_pkg::CMP_SECONDARY_OFFSET, {16'h0, sv});
		wr(tcc_pkg::CMP_CTRL_OFFSET, {16'h0, ctrl});
		repeat (3) @(posedge clk);
		chk("initial level", {31'h0, lv[1]}, {31'h0, compare_output_pin});
		cmp_irqs = 0;
		sweep(ctrl[3]);
		sweep(ctrl[3]);
		repeat (3) @(posedge clk);
		chk("final level", {31'h0, lv[0]}, {31'h0, compare_output_pin});
		chk("compare irqs", irqs, cmp_irqs);
	endtask
	// ====
	// Main sequence
	initial begin
		logic [31:0] r;
		logic e;
		logic [15:0] cc[12] = '{16'h0083, 16'h0002, 16'h0021, 16'h0004, 16'h0005, 16'h0000, 16'h0006, 16'h00A3,
			16'h0063, 16'h2003, 16'h0003, 16'h0007};
		int cn[12] = '{1, 2, 2, 8, 16, 2, 2, 3, 5, 2, 2, 2};
		logic [1:0] cp[12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
		logic [15:0] mc[6] = '{16'h0001, 16'h000A, 16'h0003, 16'h0004, 16'h000D, 16'h0006};
		logic [15:0] mp[6] = '{16'h0005, 16'h0005, 16'h0002, 16'h0002, 16'h0002, 16'h0003};
		logic [15:0] ms[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0005, 16'h0005, 16'h0006};
		logic [1:0] ml[6] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2};
		int mi[6] = '{1, 1, 2, 1, 2, 0};
		logic [7:0] offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
		reset = 1'b1;
		{psel, penable, pwrite, cpu_idle, cpu_sleep, port_output_value} = 6'h00;
		paddr = 32'h0;
		pwdata = 32'h0;
		first_timer_count = 16'hFFFF;
		second_timer_count = 16'hFFFF;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) rdc("reset value", offs[i], 32'h0);
		wr(tcc_pkg::CAP_CTRL_OFFSET, 32'hFFFFFFFF);
		rdc("capture control bits", tcc_pkg::CAP_CTRL_OFFSET, 32'h000020E7);
		wr(tcc_pkg::CMP_CTRL_OFFSET, 32'hFFFFFFFF);
		rdc("compare control bits", tcc_pkg::CMP_CTRL_OFFSET, 32'h0000200F);
		apb(1'b0, 8'h14, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		for (int i = 0; i < 12; i++) cap_run(cc[i], cn[i], cp[i]);
		for (int i = 0; i < 6; i++) cmp_run(mc[i], mp[i], ms[i], ml[i], mi[i]);
		cmp_run(16'h0007, 16'h0003, 16'h0006, 2'h2, 0);
		cmp_irqs = 0;
		u_tcc_far_side.fault(4);
		repeat (3) @(posedge clk);
		chk("fault irq", 32'h1, cmp_irqs);
		chk("fault pin", 32'h0, {31'h0, compare_output_pin});
		rdc("fault status", tcc_pkg::CMP_CTRL_OFFSET, 32'h00000017);
		sweep(1'b0);
		rdc("fault cleared", tcc_pkg::CMP_CTRL_OFFSET, 32'h00000007);
		wr(tcc_pkg::CMP_CTRL_OFFSET, 32'h0);
		port_output_value <= 1'b1;
		repeat (3) @(posedge clk);
		chk("port level", 32'h1, {31'h0, compare_output_pin});
		conclude();
	end
	// Run takes about a thousand cycles; this margin only cuts a hang
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		conclude();
	end
endmodule
